// *** core/iwc_ctrl.sv ***
// serial bus event interrupt, wait timing, address match and arbitration controller
//
// Implementation choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module iwc_ctrl #(
	parameter int HALF_CYC = iwc_pkg::SCL_HALF_CYC
) (
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	input wire iwc_pkg::iwc_axi_req_type axi_req_i,
	output iwc_pkg::iwc_axi_rsp_type axi_rsp_o,
	input wire logic serial_clock_line_i,
	output logic serial_clock_line_o,
	output logic serial_clock_line_oe_o,
	input wire logic serial_data_line_i,
	output logic serial_data_line_o,
	output logic serial_data_line_oe_o,
	output logic bus_event_irq_o
);
	localparam int DW = $clog2(HALF_CYC + 1);

	typedef struct packed {
		logic awv;
		logic [iwc_pkg::ADDR_W-1:0] aw;
		logic wv;
		logic [7:0] wd;
		logic ws;
		logic bv;
		logic [1:0] bresp;
		logic rv;
		logic [8:0] rd;
		logic [1:0] rresp;
		logic ack_en;
		logic wts;
		logic spie;
		logic [7:0] own;
		logic [7:0] shift;
		logic [7:0] txc;
		logic smp;
		logic spd;
		logic std;
		logic ackd;
		logic trc;
		logic coi;
		logic exc;
		logic ald;
		logic msts;
		logic txerr;
		iwc_pkg::iwc_phase_type phase;
		logic [3:0] cnt;
		logic armed;
		logic waiting;
		logic slv;
		logic ext;
		logic rsl;
		logic rsnm;
		logic arbp;
		logic ackq;
		iwc_pkg::iwc_op_type op;
		logic mscl;
		logic msda;
		logic [DW-1:0] div;
		logic irq;
	} iwc_state_type;

	iwc_state_type st_q;
	iwc_state_type st_d;

	logic scl_s, sda_s, fall, rise, start_ev, stop_ev;
	logic wr, wr_ctl, wr_shift, wr_own, trg_st, trg_sp, trg_rel, trg_exit;
	logic tick, part, tx_on, ack_on, fl, arb_ev, ext_now, match_now;
	logic [7:0] nb;

	iwc_line_sync u_sync (
		.ref_clk_i(ref_clk_i),
		.rst_b_i(rst_b_i),
		.scl_i(serial_clock_line_i),
		.sda_i(serial_data_line_i),
		.scl_o(scl_s),
		.sda_o(sda_s),
		.fall_o(fall),
		.rise_o(rise),
		.start_o(start_ev),
		.stop_o(stop_ev)
	);

	assign wr = st_q.awv & st_q.wv & ~st_q.bv;
	assign wr_ctl = wr & st_q.ws & st_q.aw == iwc_pkg::OFS_CTRL;
	assign wr_shift = wr & st_q.ws & st_q.aw == iwc_pkg::OFS_SHIFT;
	assign wr_own = wr & st_q.ws & st_q.aw == iwc_pkg::OFS_OWN;
	assign trg_st = wr_ctl & st_q.wd[iwc_pkg::CTL_START_REQ];
	assign trg_sp = wr_ctl & st_q.wd[iwc_pkg::CTL_STOP_REQ];
	assign trg_rel = wr_ctl & st_q.wd[iwc_pkg::CTL_WAIT_REL];
	assign trg_exit = wr_ctl & st_q.wd[iwc_pkg::CTL_EXIT_COMM];
	assign tick = st_q.div == '0;
	assign part = st_q.msts | st_q.slv | st_q.ext;
	assign tx_on = (st_q.phase == iwc_pkg::PH_ADDR & st_q.msts) | (st_q.phase == iwc_pkg::PH_DATA & st_q.trc & part);
	assign ack_on = st_q.phase == iwc_pkg::PH_ADDR ? st_q.ackq : (~st_q.trc & part & st_q.ack_en);
	// the start condition's own falling edge is not counted
	assign fl = fall & st_q.armed & st_q.phase != iwc_pkg::PH_IDLE;
	assign arb_ev = rise & st_q.msts & tx_on & st_q.cnt < 4'd8 & st_q.shift[7] & ~sda_s;
	// byte as it stands once the current bit is shifted in
	assign nb = {st_q.shift[6:0], st_q.smp};
	assign ext_now = nb[7:4] == 4'h0 | nb[7:4] == 4'hF;
	assign match_now = nb[7:1] == st_q.own[7:1];

	always_comb begin
		st_d = st_q;
		st_d.irq = 1'b0;
		st_d.div = tick ? DW'(HALF_CYC - 1) : st_q.div - 1'b1;
		// register bus: address and data accepted in either order
		if (axi_req_i.awvalid & ~st_q.awv) begin
			st_d.awv = 1'b1;
			st_d.aw = axi_req_i.awaddr;
		end
		if (axi_req_i.wvalid & ~st_q.wv) begin
			st_d.wv = 1'b1;
			st_d.wd = axi_req_i.wdata[7:0];
			st_d.ws = axi_req_i.wstrb[0];
		end
		if (st_q.bv & axi_req_i.bready) begin
			st_d.bv = 1'b0;
		end
		if (wr) begin
			st_d.awv = 1'b0;
			st_d.wv = 1'b0;
			st_d.bv = 1'b1;
			st_d.bresp = st_q.aw[1:0] == 2'h0 & st_q.aw <= iwc_pkg::OFS_OWN ? iwc_pkg::RESP_OKAY : iwc_pkg::RESP_SLVERR;
		end
		if (wr_ctl) begin
			st_d.ack_en = st_q.wd[iwc_pkg::CTL_AUTO_ACK];
			st_d.wts = st_q.wd[iwc_pkg::CTL_WAIT_SEL];
			st_d.spie = st_q.wd[iwc_pkg::CTL_STOP_IRQ];
		end
		if (wr_own) begin
			st_d.own = st_q.wd;
		end
		if (wr_shift) begin
			st_d.shift = st_q.wd;
			st_d.txc = st_q.wd;
			st_d.txerr = 1'b0;
		end
		if (st_q.rv & axi_req_i.rready) begin
			st_d.rv = 1'b0;
		end
		if (axi_req_i.arvalid & ~st_q.rv) begin
			st_d.rv = 1'b1;
			st_d.rresp = iwc_pkg::RESP_OKAY;
			case (axi_req_i.araddr)
				iwc_pkg::OFS_CTRL: st_d.rd = {4'h0, st_q.spie, st_q.wts, st_q.ack_en, 2'h0};
				iwc_pkg::OFS_STAT: begin
					st_d.rd = {st_q.txerr, st_q.msts, st_q.ald, st_q.exc, st_q.coi, st_q.trc, st_q.ackd, st_q.std, st_q.spd};
					st_d.ald = 1'b0;
				end
				iwc_pkg::OFS_SHIFT: st_d.rd = {1'b0, st_q.shift};
				iwc_pkg::OFS_OWN: st_d.rd = {1'b0, st_q.own};
				default: begin
					st_d.rd = '0;
					st_d.rresp = iwc_pkg::RESP_SLVERR;
				end
			endcase
		end
		if (wr_shift | trg_rel | (st_q.msts & (trg_st | trg_sp))) begin
			st_d.waiting = 1'b0;
			// start pull-down must not linger into the address bits
			if (st_q.op == iwc_pkg::OP_NONE) begin
				st_d.msda = 1'b0;
			end
		end
		// a request is ignored while another master sequence runs
		if (trg_st & st_q.op == iwc_pkg::OP_NONE & (st_q.msts | st_q.phase == iwc_pkg::PH_IDLE)) begin
			st_d.op = iwc_pkg::OP_ST_REL;
			st_d.msts = 1'b1;
		end else if (trg_sp & st_q.msts & st_q.op == iwc_pkg::OP_NONE) begin
			st_d.op = iwc_pkg::OP_SP_LOW;
		end
		if (trg_exit) begin
			st_d.slv = 1'b0;
			st_d.ext = 1'b0;
			st_d.coi = 1'b0;
			st_d.exc = 1'b0;
			st_d.waiting = 1'b0;
			st_d.phase = iwc_pkg::PH_IDLE;
		end
		if (tick) begin
			case (st_q.op)
				iwc_pkg::OP_NONE: begin
					if (st_q.msts & ~st_q.waiting & st_q.phase != iwc_pkg::PH_IDLE) begin
						// high phase waits for the line to be seen high: clock synchronisation
						if (st_q.mscl) begin
							st_d.mscl = 1'b0;
						end else if (scl_s) begin
							st_d.mscl = 1'b1;
						end
					end
				end
				iwc_pkg::OP_ST_REL: begin
					st_d.msda = 1'b0;
					st_d.op = iwc_pkg::OP_ST_RISE;
				end
				iwc_pkg::OP_ST_RISE: begin
					st_d.mscl = 1'b0;
					st_d.op = iwc_pkg::OP_ST_HIGH;
				end
				iwc_pkg::OP_ST_HIGH: begin
					if (scl_s) begin
						st_d.msda = sda_s;
						st_d.op = iwc_pkg::OP_ST_LOW;
					end
				end
				iwc_pkg::OP_ST_LOW: begin
					st_d.mscl = 1'b1;
					st_d.waiting = 1'b1;
					st_d.op = iwc_pkg::OP_NONE;
				end
				iwc_pkg::OP_SP_LOW: begin
					st_d.msda = 1'b1;
					st_d.op = iwc_pkg::OP_SP_REL;
				end
				iwc_pkg::OP_SP_REL: begin
					st_d.mscl = 1'b0;
					st_d.op = iwc_pkg::OP_SP_HIGH;
				end
				iwc_pkg::OP_SP_HIGH: begin
					if (scl_s) begin
						st_d.msda = 1'b0;
						st_d.op = iwc_pkg::OP_NONE;
					end
				end
				default: st_d.op = iwc_pkg::OP_NONE;
			endcase
		end
		if (rise & st_q.phase != iwc_pkg::PH_IDLE) begin
			st_d.armed = 1'b1;
			st_d.smp = sda_s;
			if (st_q.cnt == 4'd8) begin
				st_d.ackd = ~sda_s;
			end
		end
		if (arb_ev) begin
			st_d.ald = 1'b1;
			st_d.msts = 1'b0;
			st_d.mscl = 1'b0;
			st_d.msda = 1'b0;
			st_d.waiting = 1'b0;
			st_d.arbp = 1'b1;
		end
		if (fl) begin
			st_d.cnt = st_q.cnt == 4'd8 ? 4'd0 : st_q.cnt + 4'd1;
			if (st_q.cnt < 4'd8) begin
				st_d.shift = nb;
			end
			if (st_q.cnt == 4'd7) begin
				if (tx_on & nb != st_q.txc) begin
					st_d.txerr = 1'b1;
				end
				if (st_q.phase == iwc_pkg::PH_ADDR) begin
					if (st_q.msts) begin
						st_d.trc = ~nb[0];
					end else if (ext_now) begin
						st_d.exc = 1'b1;
						st_d.coi = match_now;
						st_d.ext = 1'b1;
						st_d.slv = match_now;
						st_d.trc = nb[0];
						st_d.ackq = st_q.ack_en | match_now;
						st_d.irq = 1'b1;
						st_d.waiting = 1'b1;
						st_d.arbp = 1'b0;
					end else if (match_now) begin
						st_d.coi = 1'b1;
						st_d.slv = 1'b1;
						st_d.trc = nb[0];
						st_d.ackq = 1'b1;
					end else if (st_q.rsl) begin
						st_d.rsnm = 1'b1;
					end else if (~st_q.arbp) begin
						st_d.phase = iwc_pkg::PH_IDLE;
					end
				end else if (~st_q.wts & (part | st_q.arbp)) begin
					st_d.irq = 1'b1;
					st_d.waiting = part;
					st_d.arbp = 1'b0;
					if (~part) begin
						st_d.phase = iwc_pkg::PH_IDLE;
					end
				end
			end
			if (st_q.cnt == 4'd8) begin
				if (st_q.phase == iwc_pkg::PH_ADDR) begin
					st_d.phase = iwc_pkg::PH_DATA;
					if (st_q.msts | (st_q.slv & ~st_q.ext)) begin
						st_d.irq = 1'b1;
						st_d.waiting = 1'b1;
					end else if (st_q.rsnm | st_q.arbp) begin
						st_d.irq = 1'b1;
						st_d.phase = iwc_pkg::PH_IDLE;
					end else if (~st_q.ext) begin
						st_d.phase = iwc_pkg::PH_IDLE;
					end
					st_d.rsnm = 1'b0;
					st_d.arbp = 1'b0;
					st_d.ackq = 1'b0;
				end else if (st_q.wts & (part | st_q.arbp)) begin
					st_d.irq = 1'b1;
					st_d.waiting = part;
					st_d.arbp = 1'b0;
					if (~part) begin
						st_d.phase = iwc_pkg::PH_IDLE;
					end
				end
			end
		end
		if (start_ev) begin
			st_d.std = 1'b1;
			st_d.spd = 1'b0;
			st_d.cnt = 4'd0;
			st_d.armed = 1'b0;
			st_d.phase = iwc_pkg::PH_ADDR;
			st_d.rsl = st_q.slv | st_q.ext;
			st_d.slv = 1'b0;
			st_d.ext = 1'b0;
			st_d.coi = 1'b0;
			st_d.exc = 1'b0;
			st_d.ackq = 1'b0;
			st_d.trc = 1'b0;
		end
		if (stop_ev) begin
			st_d.spd = 1'b1;
			st_d.std = 1'b0;
			st_d.phase = iwc_pkg::PH_IDLE;
			st_d.msts = 1'b0;
			st_d.slv = 1'b0;
			st_d.ext = 1'b0;
			st_d.waiting = 1'b0;
			st_d.arbp = 1'b0;
			st_d.irq = st_q.spie;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign serial_clock_line_o = 1'b0;
	assign serial_clock_line_oe_o = st_q.mscl | st_q.waiting;
	assign serial_data_line_o = 1'b0;
	assign serial_data_line_oe_o = (tx_on & st_q.cnt < 4'd8 & ~st_q.shift[7]) | (st_q.cnt == 4'd8 & ack_on) | st_q.msda;
	assign bus_event_irq_o = st_q.irq;
	assign axi_rsp_o = '{awready: ~st_q.awv, wready: ~st_q.wv, bvalid: st_q.bv, bresp: st_q.bresp,
		arready: ~st_q.rv, rvalid: st_q.rv, rdata: {23'h0, st_q.rd}, rresp: st_q.rresp};

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_b_i);

	sequence s_addr_f8;
		fl && st_q.phase == iwc_pkg::PH_ADDR && st_q.cnt == 4'd7;
	endsequence
	sequence s_addr_f9;
		fl && st_q.phase == iwc_pkg::PH_ADDR && st_q.cnt == 4'd8;
	endsequence

	a_stop_flag_set: assert property (stop_ev |=> st_q.spd)
		else $error("stop seen but stop flag not set");
	a_stop_irq_gate: assert property (stop_ev |=> bus_event_irq_o == $past(st_q.spie))
		else $error("stop event does not follow its enable");
	a_wait_release: assert property (st_q.waiting && wr_shift && !fl |=> !st_q.waiting)
		else $error("shift write did not end the wait");
	a_irq_aligned: assert property (bus_event_irq_o && !$past(stop_ev) |-> $past(fl))
		else $error("event not on a counted falling edge");
	a_master_addr9: assert property ((s_addr_f9 ##0 st_q.msts) |=> bus_event_irq_o && serial_clock_line_oe_o)
		else $error("master address event or wait missing at ninth edge");
	a_data_timing: assert property (fl && st_q.phase == iwc_pkg::PH_DATA && st_q.slv && !stop_ev
		&& st_q.cnt == (st_q.wts ? 4'd8 : 4'd7) |=> bus_event_irq_o && st_q.waiting)
		else $error("data event or wait at wrong edge");
	a_ext_at8: assert property ((s_addr_f8 ##0 (ext_now && !st_q.msts)) |=> bus_event_irq_o && st_q.exc)
		else $error("extension code not flagged at eighth edge");
	a_own_ack: assert property ((s_addr_f8 ##0 (match_now && !ext_now && !st_q.msts))
		|=> serial_data_line_oe_o && !bus_event_irq_o)
		else $error("own address not acknowledged");
	a_nomatch_quiet: assert property ((s_addr_f8 ##0 (!match_now && !ext_now && !st_q.msts && !st_q.rsl && !st_q.arbp))
		|=> st_q.phase == iwc_pkg::PH_IDLE && !bus_event_irq_o)
		else $error("foreign address caused activity");
	a_rs_nomatch: assert property ((s_addr_f9 ##0 (st_q.rsnm && !st_q.slv && !st_q.ext && !st_q.msts))
		|=> bus_event_irq_o && !st_q.waiting)
		else $error("restart mismatch handled wrongly");
	a_arb_release: assert property (arb_ev |=> st_q.ald && !serial_clock_line_oe_o && !st_q.msts)
		else $error("lost arbitration did not release the bus");
endmodule : iwc_ctrl

// *** core/iwc_line_sync.sv ***
// line synchronisers with clock edge, start and stop detection
`timescale 1ns/1ps
module iwc_line_sync (
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_o,
	output logic fall_o,
	output logic rise_o,
	output logic start_o,
	output logic stop_o
);
	typedef struct packed {
		logic [1:0] meta;
		logic [1:0] sync;
		logic [1:0] last;
	} iwc_sync_type;

	iwc_sync_type st_q;
	iwc_sync_type st_d;

	// bit 1 is the clock line, bit 0 the data line
	always_comb begin
		st_d.meta = {scl_i, sda_i};
		st_d.sync = st_q.meta;
		st_d.last = st_q.sync;
	end

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			st_q <= iwc_pkg::SYNC_RST;
		end else begin
			st_q <= st_d;
		end
	end

	// detection only looks at the second and third stages
	assign scl_o = st_q.sync[1];
	assign sda_o = st_q.sync[0];
	assign fall_o = st_q.last[1] & ~st_q.sync[1];
	assign rise_o = ~st_q.last[1] & st_q.sync[1];
	assign start_o = st_q.last[1] & st_q.sync[1] & st_q.last[0] & ~st_q.sync[0];
	assign stop_o = st_q.last[1] & st_q.sync[1] & ~st_q.last[0] & st_q.sync[0];
endmodule : iwc_line_sync

// *** core/iwc_pkg.sv ***
// shared constants and carrier types for the serial bus wait and event controller
package iwc_pkg;
	localparam int ADDR_W = 5;
	localparam logic [4:0] OFS_CTRL = 5'h00;
	localparam logic [4:0] OFS_STAT = 5'h04;
	localparam logic [4:0] OFS_SHIFT = 5'h08;
	localparam logic [4:0] OFS_OWN = 5'h0C;
	localparam int CTL_STOP_REQ = 0;
	localparam int CTL_START_REQ = 1;
	localparam int CTL_AUTO_ACK = 2;
	localparam int CTL_WAIT_SEL = 3;
	localparam int CTL_STOP_IRQ = 4;
	localparam int CTL_WAIT_REL = 5;
	localparam int CTL_EXIT_COMM = 6;
	localparam logic [5:0] SYNC_RST = 6'h3F;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam int CLK_NS = 50;
	localparam int SCL_HALF_NS = 5000;
	localparam int SCL_HALF_CYC = SCL_HALF_NS / CLK_NS;

	typedef struct packed {
		logic awvalid;
		logic [ADDR_W-1:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [ADDR_W-1:0] araddr;
		logic rready;
	} iwc_axi_req_type;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} iwc_axi_rsp_type;

	typedef enum logic [1:0] {
		PH_IDLE = 2'h0,
		PH_ADDR = 2'h1,
		PH_DATA = 2'h3
	} iwc_phase_type;

	typedef enum logic [2:0] {
		OP_NONE = 3'h0,
		OP_ST_REL = 3'h1,
		OP_ST_RISE = 3'h3,
		OP_ST_HIGH = 3'h2,
		OP_ST_LOW = 3'h6,
		OP_SP_LOW = 3'h7,
		OP_SP_REL = 3'h5,
		OP_SP_HIGH = 3'h4
	} iwc_op_type;
endpackage : iwc_pkg

// *** test/iwc_remote_node.sv ***
// behavioural remote master and acknowledging slave on the two-wire bus
`timescale 1ns/1ps
module iwc_remote_node (
	input wire logic scl_i,
	input wire logic sda_i,
	output logic scl_oe_o,
	output logic sda_oe_o
);
	initial begin
		scl_oe_o = 1'b0;
		sda_oe_o = 1'b0;
	end
	// odd offsets keep our edges away from the block's clock edges
	task automatic start_cond();
		#13;
		sda_oe_o = 1'b0;
		#100;
		scl_oe_o = 1'b0;
		wait (scl_i);
		#113;
		sda_oe_o = 1'b1;
		#100;
		scl_oe_o = 1'b1;
		#100;
	endtask : start_cond
	// a held-low clock is waited out, never overridden
	task automatic pulse(input logic low, output logic seen);
		sda_oe_o = low;
		#100;
		scl_oe_o = 1'b0;
		wait (scl_i);
		#103;
		seen = sda_i;
		#110;
		scl_oe_o = 1'b1;
		#100;
	endtask : pulse
	task automatic send_byte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			pulse(~b[i], s);
		end
		pulse(1'b0, s);
		ack = ~s;
	endtask : send_byte
	task automatic stop_cond();
		sda_oe_o = 1'b1;
		#100;
		scl_oe_o = 1'b0;
		wait (scl_i);
		#213;
		sda_oe_o = 1'b0;
		#200;
	endtask : stop_cond
	// slave side: pull data low through the ninth clock
	task automatic ack_ninth();
		repeat (8) @(negedge scl_i);
		sda_oe_o = 1'b1;
		@(negedge scl_i);
		sda_oe_o = 1'b0;
	endtask : ack_ninth
endmodule : iwc_remote_node

// *** test/tb.sv ***
// self-checking bench for the serial bus event and wait controller
`timescale 1ns/1ps
module tb;
	typedef struct packed {
		logic [1:0] resp;
		logic [31:0] data;
		logic [31:0] mask;
	} iwc_note_type;
	logic ref_clk_i;
	logic rst_b_i;
	iwc_pkg::iwc_axi_req_type req;
	iwc_pkg::iwc_axi_rsp_type rsp;
	logic scl_o;
	logic scl_oe;
	logic sda_o;
	logic sda_oe;
	logic irq;
	logic rn_scl_oe;
	logic rn_sda_oe;
	wire scl_w;
	wire sda_w;
	logic scl_q = 1'b1;
	logic sda_q = 1'b1;
	logic stop_seen = 1'b0;
	int fall_cnt = 0;
	int fails = 0;
	int checks = 0;
	logic [16:0] rnd;
	iwc_note_type bus_q[$];
	logic [8:0] irq_q[$];
	logic [7:0] ext [5] = '{8'h00, 8'h01, 8'h03, 8'h04, 8'hF2};
	// pull-ups: a released line reads high
	assign scl_w = (scl_oe ? scl_o : 1'b1) & ~rn_scl_oe;
	assign sda_w = (sda_oe ? sda_o : 1'b1) & ~rn_sda_oe;
	iwc_ctrl #(.HALF_CYC(4)) iwc_ctrl_inst (
		.ref_clk_i(ref_clk_i),
		.rst_b_i(rst_b_i),
		.axi_req_i(req),
		.axi_rsp_o(rsp),
		.serial_clock_line_i(scl_w),
		.serial_clock_line_o(scl_o),
		.serial_clock_line_oe_o(scl_oe),
		.serial_data_line_i(sda_w),
		.serial_data_line_o(sda_o),
		.serial_data_line_oe_o(sda_oe),
		.bus_event_irq_o(irq)
	);
	iwc_remote_node rn (
		.scl_i(scl_w),
		.sda_i(sda_w),
		.scl_oe_o(rn_scl_oe),
		.sda_oe_o(rn_sda_oe)
	);
	initial begin
		ref_clk_i = 1'b0;
		forever #25 ref_clk_i = ~ref_clk_i;
	end
	function automatic logic [16:0] lfsr(input logic [16:0] s);
		return {s[15:0], s[16] ^ s[13]};
	endfunction : lfsr
	task automatic check(input logic [33:0] seen, input logic [33:0] exp);
		checks++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value at %0t ns: seen %0h expected %0h", $time, seen, exp);
		end
	endtask : check
	task automatic summarize();
		if (fails == 0 && checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : summarize
	task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] r = iwc_pkg::RESP_OKAY);
		int n;
		@(posedge ref_clk_i);
		bus_q.push_back('{r, 32'h0, 32'h0});
		req.awaddr <= a;
		req.wdata <= d;
		req.awvalid <= 1'b1;
		req.wvalid <= 1'b1;
		req.bready <= 1'b1;
		n = 0;
		do begin
			@(posedge ref_clk_i);
			if (rsp.awready) req.awvalid <= 1'b0;
			if (rsp.wready) req.wvalid <= 1'b0;
			n++;
		end while (!rsp.bvalid && n < 100);
		req.bready <= 1'b0;
		if (n >= 100) fails++;
	endtask : wr
	task automatic rd(input logic [4:0] a, input logic [31:0] d, input logic [31:0] m,
		input logic [1:0] r = iwc_pkg::RESP_OKAY);
		int n;
		@(posedge ref_clk_i);
		bus_q.push_back('{r, d, m});
		req.araddr <= a;
		req.arvalid <= 1'b1;
		req.rready <= 1'b1;
		n = 0;
		do begin
			@(posedge ref_clk_i);
			if (rsp.arready) req.arvalid <= 1'b0;
			n++;
		end while (!rsp.rvalid && n < 100);
		req.rready <= 1'b0;
		if (n >= 100) fails++;
	endtask : rd
	// waits for the event, checks the clock hold and, when sm is nonzero, the status, then writes d to a if held
	task automatic hold_rel(input logic [4:0] a, input logic [31:0] d, input logic held,
		input logic [31:0] st, input logic [31:0] sm);
		int n;
		n = 0;
		while (irq !== 1'b1 && n < 4000) begin
			@(posedge ref_clk_i);
			n++;
		end
		repeat (20) @(posedge ref_clk_i);
		check({33'h0, scl_oe}, {33'h0, held});
		if (sm != 0) rd(iwc_pkg::OFS_STAT, st, sm);
		if (held) wr(a, d);
	endtask : hold_rel
	task automatic xfer(input logic [7:0] b, input logic [8:0] ev, input logic [31:0] ctl, input logic held,
		input logic ack_exp, input logic [31:0] st, input logic [31:0] sm);
		logic ack;
		if (ev != 0) irq_q.push_back(ev);
		fork
			rn.send_byte(b, ack);
			if (ev != 0) hold_rel(iwc_pkg::OFS_CTRL, ctl, held, st, sm);
		join
		if (ack_exp !== 1'bx) check({33'h0, ack}, {33'h0, ack_exp});
	endtask : xfer
	// edges, start and stop found on the wire; fall count restarts at every start
	always @(posedge ref_clk_i) begin
		iwc_note_type n;
		scl_q <= scl_w;
		sda_q <= sda_w;
		if (scl_w && sda_q && !sda_w) begin
			fall_cnt <= -1;
			stop_seen <= 1'b0;
		end else if (scl_w && !sda_q && sda_w) begin
			stop_seen <= 1'b1;
		end else if (scl_q && !scl_w) begin
			fall_cnt <= fall_cnt + 1;
		end
		if (irq === 1'b1) begin
			if (irq_q.size() == 0) begin
				check(34'h1, 34'h0);
			end else begin
				check(34'({stop_seen, fall_cnt[7:0]}), 34'(irq_q.pop_front()));
			end
		end
		if (rsp.bvalid && req.bready && bus_q.size() > 0) begin
			n = bus_q.pop_front();
			check({rsp.bresp, 32'h0}, {n.resp, 32'h0});
		end
		if (rsp.rvalid && req.rready && bus_q.size() > 0) begin
			n = bus_q.pop_front();
			check({rsp.rresp, rsp.rdata & n.mask}, {n.resp, n.data & n.mask});
		end
	end
	initial begin
		#2000000;
		fails++;
		summarize();
	end
	initial begin
		req = '0;
		req.wstrb = 4'hF;
		rst_b_i = 1'b0;
		rnd = 17'h15397;
		repeat (2) @(posedge ref_clk_i);
		rst_b_i <= 1'b1;
		rd(iwc_pkg::OFS_CTRL, 32'h0, 32'hFFFFFFFF);
		rd(iwc_pkg::OFS_STAT, 32'h0, 32'h1FF);
		rd(5'h10, 32'h0, 32'h0, iwc_pkg::RESP_SLVERR);
		wr(5'h02, 32'h0, iwc_pkg::RESP_SLVERR);
		wr(iwc_pkg::OFS_OWN, 32'hA4);
		wr(iwc_pkg::OFS_CTRL, 32'h1C);
		rd(iwc_pkg::OFS_CTRL, 32'h1C, 32'h7F);
		// slave: own address with auto ack off, nine-clock then eight-clock data
		wr(iwc_pkg::OFS_CTRL, 32'h08);
		rn.start_cond();
		xfer(8'hA4, 9'h009, 32'h2C, 1'b1, 1'b1, 32'h10, 32'h30);
		rnd = lfsr(rnd);
		xfer(rnd[7:0], 9'h012, 32'h24, 1'b1, 1'b1, 32'h0, 32'h0);
		rnd = lfsr(rnd);
		xfer(rnd[7:0], 9'h01A, 32'h24, 1'b1, 1'b1, 32'h0, 32'h0);
		rn.start_cond();
		xfer(8'h30, 9'h009, 32'h0, 1'b0, 1'b0, 32'h0, 32'h0);
		rn.stop_cond();
		rd(iwc_pkg::OFS_STAT, 32'h1, 32'h1);
		// foreign address, then stop with its interrupt enabled
		wr(iwc_pkg::OFS_CTRL, 32'h10);
		rn.start_cond();
		xfer(8'h30, 9'h000, 32'h0, 1'b0, 1'b0, 32'h0, 32'h0);
		irq_q.push_back(9'h109);
		rn.stop_cond();
		repeat (20) @(posedge ref_clk_i);
		// five extension codes; the last one also equals the ten-bit prefix
		wr(iwc_pkg::OFS_OWN, 32'hF2);
		wr(iwc_pkg::OFS_CTRL, 32'h00);
		foreach (ext[i]) begin
			rn.start_cond();
			xfer(ext[i], 9'h008, 32'h40, 1'b1, 1'bx, {26'h0, 1'b1, ext[i][7:1] == 7'h79, 4'h0}, 32'h30);
			rn.stop_cond();
		end
		// own master: address event at nine despite eight-clock select
		wr(iwc_pkg::OFS_CTRL, 32'h02);
		repeat (60) @(posedge ref_clk_i);
		irq_q.push_back(9'h009);
		fork
			rn.ack_ninth();
			wr(iwc_pkg::OFS_SHIFT, 32'h5A);
			hold_rel(iwc_pkg::OFS_CTRL, 32'h08, 1'b1, 32'h80, 32'h80);
		join
		irq_q.push_back(9'h012);
		rnd = lfsr(rnd);
		fork
			rn.ack_ninth();
			wr(iwc_pkg::OFS_SHIFT, {24'h0, rnd[7:0]});
			hold_rel(iwc_pkg::OFS_CTRL, 32'h09, 1'b1, 32'h80, 32'h180);
		join
		repeat (100) @(posedge ref_clk_i);
		rd(iwc_pkg::OFS_STAT, 32'h1, 32'h1);
		check(34'(irq_q.size()), 34'h0);
		summarize();
	end
endmodule : tb
